/* File: rtl/link_ctrl_params.svh */
// offsets, field positions and reset values of the host-bus link control bank
`ifndef LINK_CTRL_PARAMS_SVH
`define LINK_CTRL_PARAMS_SVH

`define BIC_ADDR        16'h5B00
`define FTS_ADDR        16'h5B08
`define WORD_LSB        2

`define BIC_RESET       32'h0680_0200
`define FTS_RESET       32'h0000_0000
// bits software may change: 31..27, 24, 22, 21, 9, 5..0
`define BIC_SW_MASK     32'hF960_023F
`define FTS_SW_MASK     32'hFFFF_FFFF

`define BIT_TMO_DIS     31
`define BIT_SELFTEST    30
`define BIT_FORCE_L0S   29
`define BIT_DISP_MASK   28
`define BIT_L1_FREE     27
`define LAT_LSB_HI      26
`define LAT_LSB_LO      25
`define BIT_ENTRY_SEL   24
`define LAT_MSB         23
`define BIT_INIT_ONE    22
`define BIT_HDR_ORDER   21
`define BIT_REPLAY_PAD  9
`define NOSNOOP_HI      5
`define NOSNOOP_LO      0

`define FT_LANE_W       8
`define FT_FUNC_LO      0
`define FT_FUNC_W       5
`define FT_TAG_LO       5
`define FT_TAG_W        3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

/* File: rtl/link_ctrl_pkg.sv */
// types shared by the host-bus link control bank
package link_ctrl_pkg;

  // per-traffic-class no-snoop attributes, msb first as in the register
  typedef struct packed {
    logic tx_desc_fetch_nosnoop_attr;
    logic tx_desc_writeback_nosnoop_attr;
    logic tx_payload_fetch_nosnoop_attr;
    logic rx_desc_fetch_nosnoop_attr;
    logic rx_desc_writeback_nosnoop_attr;
    logic rx_payload_store_nosnoop_attr;
  } nosnoop_attr_t;

  // one completion event seen by the statistic counters
  typedef struct packed {
    logic       valid;
    logic [2:0] tag;
    logic [4:0] func;
  } tag_event_t;

endpackage

/* File: rtl/pcie_link_control_regs.sv */
// host-bus link control register bank with AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "link_ctrl_params.svh"

// Contract
// - timeout-disable bit set suppresses completion time-out reporting.
// - self-test result bit reads zero until hardware reports self-test success; software can also set it, since bit 30 is in BIC_SW_MASK.
// - force-training bit makes standby link training report success.
// - disparity mask bit stops disparity errors from the link decoders.
// - l1-free bit allows deep-sleep entry regardless of receiver standby.
// - three-bit deep-sleep idle delay is read-only, nonvolatile-loaded, resets to 111b.
// - entry-delay select bit advertises standby entry as exit or quarter exit.
// - header-order bit selects the alternate error header log order.
// - replay pad bit one always pads; zero pads only during transmit standby.
// - six no-snoop bits drive transaction-layer attributes per traffic class.
// - counter 0 qualifier: tag bits 7:5, function bits 4:0.
// - counters 1 and 3 qualifiers at 15:13/12:8 and 31:29/28:24; counter 2 function 20:16.
module pcie_link_control_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic [ADDR_W-1:0]           s_axi_awaddr_i,
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [31:0]                 s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  output logic [1:0]                       s_axi_bresp_o,
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]           s_axi_araddr_i,
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  output logic [31:0]                      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i,
  input  wire logic                        self_test_pass_i,
  input  wire logic                        nvm_load_i,
  input  wire logic [2:0]                  nvm_idle_delay_i,
  input  wire logic                        cpl_timeout_hit_i,
  output logic                             cpl_timeout_err_o,
  input  wire logic                        training_ok_i,
  output logic                             standby_training_ok_o,
  input  wire logic                        disparity_err_raw_i,
  output logic                             disparity_err_o,
  input  wire logic                        l1_req_i,
  input  wire logic                        rx_standby_i,
  output logic                             l1_entry_allowed_o,
  input  wire logic                        tx_standby_i,
  output logic                             replay_pad_active_o,
  output logic [2:0]                       deep_sleep_idle_delay_o,
  output logic                             standby_entry_delay_sel_o,
  output logic                             header_log_alt_order_o,
  output link_ctrl_pkg::nosnoop_attr_t     nosnoop_o,
  input  wire link_ctrl_pkg::tag_event_t   tag_event_i,
  output logic [3:0]                       qual_match_o
);

  localparam int NUM_CNT = 4;
  // decode compares word addresses of the bus width, low byte-lane bits ignored
  localparam logic [ADDR_W-1:0] BIC_A = ADDR_W'(`BIC_ADDR);
  localparam logic [ADDR_W-1:0] FTS_A = ADDR_W'(`FTS_ADDR);

  // register contents, read by the bus decode below
  logic [31:0] bic_q, bic_d;
  logic [31:0] fts_q, fts_d;

  // bus channel state
  logic              aw_have_q, aw_have_d;
  logic              w_have_q,  w_have_d;
  logic [ADDR_W-1:0] awaddr_q,  awaddr_d;
  logic [31:0]       wdata_q,   wdata_d;
  logic [3:0]        wstrb_q,   wstrb_d;
  logic              awready_q, awready_d;
  logic              wready_q,  wready_d;
  logic              bvalid_q,  bvalid_d;
  logic [1:0]        bresp_q,   bresp_d;
  logic              arready_q, arready_d;
  logic              rvalid_q,  rvalid_d;
  logic [1:0]        rresp_q,   rresp_d;
  logic [31:0]       rdata_q,   rdata_d;

  logic              aw_hs, w_hs, ar_hs, wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [31:0]       byte_mask;
  logic              wr_bic, wr_fts, rd_bic, rd_fts;

  always_comb begin
    aw_hs     = s_axi_awvalid_i & awready_q;
    w_hs      = s_axi_wvalid_i & wready_q;
    ar_hs     = s_axi_arvalid_i & arready_q;
    aw_have_d = aw_have_q | aw_hs;
    w_have_d  = w_have_q | w_hs;
    awaddr_d  = aw_hs ? s_axi_awaddr_i : awaddr_q;
    wdata_d   = w_hs ? s_axi_wdata_i : wdata_q;
    wstrb_d   = w_hs ? s_axi_wstrb_i : wstrb_q;
    // address and data may arrive in either order; commit once both are held
    wr_fire   = aw_have_d & w_have_d;
    wr_addr   = awaddr_d;
    wr_data   = wdata_d;
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{wstrb_d[i]}};
    end
    wr_bic = wr_addr[ADDR_W-1:`WORD_LSB] == BIC_A[ADDR_W-1:`WORD_LSB];
    wr_fts = wr_addr[ADDR_W-1:`WORD_LSB] == FTS_A[ADDR_W-1:`WORD_LSB];
    rd_bic = s_axi_araddr_i[ADDR_W-1:`WORD_LSB] == BIC_A[ADDR_W-1:`WORD_LSB];
    rd_fts = s_axi_araddr_i[ADDR_W-1:`WORD_LSB] == FTS_A[ADDR_W-1:`WORD_LSB];
    bvalid_d = bvalid_q & ~s_axi_bready_i;
    bresp_d  = bresp_q;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wr_bic | wr_fts) ? `RESP_OKAY : `RESP_SLVERR;
    end
    // no new beat is taken while a response is still owed
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d  = ~w_have_d & ~bvalid_d;
    rvalid_d  = rvalid_q & ~s_axi_rready_i;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (ar_hs) begin
      rvalid_d = 1'b1;
      rresp_d  = (rd_bic | rd_fts) ? `RESP_OKAY : `RESP_SLVERR;
      rdata_d  = rd_bic ? bic_q : (rd_fts ? fts_q : 32'h0000_0000);
    end
    arready_d = ~rvalid_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // register update
  logic [31:0] bic_wmask;

  always_comb begin
    bic_wmask = byte_mask & `BIC_SW_MASK;
    bic_d     = bic_q;
    fts_d     = fts_q;
    if (wr_fire && wr_bic) begin
      bic_d = (bic_q & ~bic_wmask) | (wr_data & bic_wmask);
    end
    if (wr_fire && wr_fts) begin
      fts_d = (fts_q & ~(byte_mask & `FTS_SW_MASK)) | (wr_data & byte_mask & `FTS_SW_MASK);
    end
    // hardware success report wins over a software clear in the same cycle
    if (self_test_pass_i) begin
      bic_d[`BIT_SELFTEST] = 1'b1;
    end
    if (nvm_load_i) begin
      bic_d[`LAT_MSB]                 = nvm_idle_delay_i[2];
      bic_d[`LAT_LSB_HI:`LAT_LSB_LO]  = nvm_idle_delay_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bic_q <= `BIC_RESET;
      fts_q <= `FTS_RESET;
    end else begin
      bic_q <= bic_d;
      fts_q <= fts_d;
    end
  end

  // device-facing controls, all registered
  logic                         tmo_err_q, tmo_err_d;
  logic                         train_ok_q, train_ok_d;
  logic                         disp_q, disp_d;
  logic                         l1_ok_q, l1_ok_d;
  logic                         pad_q, pad_d;
  logic [2:0]                   idle_q, idle_d;
  logic                         entry_q, entry_d;
  logic                         hdr_q, hdr_d;
  link_ctrl_pkg::nosnoop_attr_t nosnoop_q, nosnoop_d;
  logic [3:0]                   match_q, match_d;

  always_comb begin
    tmo_err_d  = cpl_timeout_hit_i & ~bic_q[`BIT_TMO_DIS];
    train_ok_d = training_ok_i | bic_q[`BIT_FORCE_L0S];
    disp_d     = disparity_err_raw_i & ~bic_q[`BIT_DISP_MASK];
    // default couples deep-sleep entry to receiver standby
    l1_ok_d    = l1_req_i & (rx_standby_i | bic_q[`BIT_L1_FREE]);
    pad_d      = bic_q[`BIT_REPLAY_PAD] | tx_standby_i;
    // code 0..7 = 2, 8, 16, 32, 64, 256 us, 1 ms, 4 ms
    idle_d     = {bic_q[`LAT_MSB], bic_q[`LAT_LSB_HI:`LAT_LSB_LO]};
    entry_d    = bic_q[`BIT_ENTRY_SEL];
    hdr_d      = bic_q[`BIT_HDR_ORDER];
    nosnoop_d  = bic_q[`NOSNOOP_HI:`NOSNOOP_LO];
    // tag-filtered events qualified per counter lane
    for (int i = 0; i < NUM_CNT; i++) begin
      match_d[i] = tag_event_i.valid
                   & (tag_event_i.tag == fts_q[i*`FT_LANE_W+`FT_TAG_LO +: `FT_TAG_W])
                   & (tag_event_i.func == fts_q[i*`FT_LANE_W+`FT_FUNC_LO +: `FT_FUNC_W]);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tmo_err_q  <= 1'b0;
      train_ok_q <= 1'b0;
      disp_q     <= 1'b0;
      l1_ok_q    <= 1'b0;
      pad_q      <= 1'b0;
      idle_q     <= 3'h0;
      entry_q    <= 1'b0;
      hdr_q      <= 1'b0;
      nosnoop_q  <= '0;
      match_q    <= 4'h0;
    end else begin
      tmo_err_q  <= tmo_err_d;
      train_ok_q <= train_ok_d;
      disp_q     <= disp_d;
      l1_ok_q    <= l1_ok_d;
      pad_q      <= pad_d;
      idle_q     <= idle_d;
      entry_q    <= entry_d;
      hdr_q      <= hdr_d;
      nosnoop_q  <= nosnoop_d;
      match_q    <= match_d;
    end
  end

  assign s_axi_awready_o           = awready_q;
  assign s_axi_wready_o            = wready_q;
  assign s_axi_bvalid_o            = bvalid_q;
  assign s_axi_bresp_o             = bresp_q;
  assign s_axi_arready_o           = arready_q;
  assign s_axi_rvalid_o            = rvalid_q;
  assign s_axi_rresp_o             = rresp_q;
  assign s_axi_rdata_o             = rdata_q;
  assign cpl_timeout_err_o         = tmo_err_q;
  assign standby_training_ok_o     = train_ok_q;
  assign disparity_err_o           = disp_q;
  assign l1_entry_allowed_o        = l1_ok_q;
  assign replay_pad_active_o       = pad_q;
  assign deep_sleep_idle_delay_o   = idle_q;
  assign standby_entry_delay_sel_o = entry_q;
  assign header_log_alt_order_o    = hdr_q;
  assign nosnoop_o                 = nosnoop_q;
  assign qual_match_o              = match_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_timeout_gate: assert property (cpl_timeout_hit_i && bic_q[`BIT_TMO_DIS] |=> !cpl_timeout_err_o)
    else $error("completion time-out reported while disabled");
  chk_selftest_set: assert property (self_test_pass_i |=> bic_q[`BIT_SELFTEST])
    else $error("self-test result bit not set after pass");
  chk_force_training: assert property (bic_q[`BIT_FORCE_L0S] |=> standby_training_ok_o)
    else $error("forced training did not report success");
  chk_disp_mask: assert property (bic_q[`BIT_DISP_MASK] && disparity_err_raw_i |=> !disparity_err_o)
    else $error("masked disparity error reported");
  chk_l1_free: assert property (l1_req_i && !rx_standby_i && bic_q[`BIT_L1_FREE] |=> l1_entry_allowed_o)
    else $error("deep-sleep entry blocked with l1-free set");
  chk_delay_readonly: assert property (wr_fire && wr_bic && !nvm_load_i
                                       |=> {bic_q[`LAT_MSB], bic_q[`LAT_LSB_HI:`LAT_LSB_LO]}
                                           == $past({bic_q[`LAT_MSB], bic_q[`LAT_LSB_HI:`LAT_LSB_LO]}))
    else $error("software write changed idle delay field");
  chk_entry_sel: assert property (##1 standby_entry_delay_sel_o == $past(bic_q[`BIT_ENTRY_SEL]))
    else $error("entry delay select does not follow register");
  chk_header_order: assert property ($rose(bic_q[`BIT_HDR_ORDER]) |=> header_log_alt_order_o)
    else $error("header order not applied");
  chk_replay_pad: assert property (!bic_q[`BIT_REPLAY_PAD] && !tx_standby_i |=> !replay_pad_active_o)
    else $error("replay pad added outside transmit standby");
  chk_nosnoop_drive: assert property (wr_fire && wr_bic && byte_mask[0] && !bvalid_q
                                      |=> ##1 nosnoop_o == $past(wr_data[`NOSNOOP_HI:`NOSNOOP_LO], 2))
    else $error("no-snoop attributes do not follow write");
  chk_cnt0_match: assert property (tag_event_i.valid && tag_event_i.tag == fts_q[7:5]
                                   && tag_event_i.func == fts_q[4:0] |=> qual_match_o[0])
    else $error("counter 0 qualifier missed");
  chk_cnt3_match: assert property (tag_event_i.valid && tag_event_i.tag != fts_q[31:29] |=> !qual_match_o[3])
    else $error("counter 3 matched wrong tag");
  chk_cnt2_tag: assert property (tag_event_i.valid && tag_event_i.tag == fts_q[23:21]
                                 && tag_event_i.func == fts_q[20:16] |=> qual_match_o[2])
    else $error("counter 2 qualifier missed");
  chk_reserved_zero: assert property (bic_q[20:10] == 11'h000 && bic_q[8:6] == 3'h0)
    else $error("reserved bits changed");
  chk_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                                     |=> s_axi_bvalid_o)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read response late");

  cov_init_write: cover property (wr_fire && wr_bic && wr_data[`BIT_INIT_ONE] && byte_mask[16]);
  cov_selftest_clash: cover property (self_test_pass_i && wr_fire && wr_bic);
  cov_split_write: cover property (aw_hs && !w_hs ##[1:4] w_hs);
  cov_unmapped_read: cover property (ar_hs && !rd_bic && !rd_fts);

endmodule

/* File: tb/link_side_model.sv */
// link-side model: puts the bench's requests onto the device's link and status inputs
`timescale 1ns/1ns
module link_side_model (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic [7:0]                 req_i,
  input  wire logic [2:0]                 delay_i,
  input  wire link_ctrl_pkg::tag_event_t  ev_i,
  output logic [7:0]                      lvl_o,
  output logic [2:0]                      delay_o,
  output link_ctrl_pkg::tag_event_t       ev_o
);
  // idle delay and event fields only mean something with their strobe;
  // otherwise they toggle so the design cannot lean on stale values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_o   <= 8'h00;
      delay_o <= 3'h0;
      ev_o    <= '0;
    end else begin
      lvl_o   <= req_i;
      delay_o <= req_i[7] ? delay_i : ~delay_o;
      ev_o    <= ev_i.valid ? ev_i : {1'b0, ~ev_o.tag, ~ev_o.func};
    end
  end
endmodule

/* File: tb/test_pcie_link_control_regs.sv */
// self-checking bench for the host-bus link control register bank
`timescale 1ns/1ns
`include "link_ctrl_params.svh"
module test_pcie_link_control_regs;
  logic                       clk_i = 1'b0;
  logic                       rst_i = 1'b1;
  logic [15:0]                awaddr = 16'h0000;
  logic [15:0]                araddr = 16'h0000;
  logic [31:0]                wdata = 32'h0000_0000;
  logic                       awvalid = 1'b0;
  logic                       wvalid = 1'b0;
  logic                       bready = 1'b0;
  logic                       arvalid = 1'b0;
  logic                       rready = 1'b0;
  logic                       awready, wready, bvalid, arready, rvalid;
  logic [1:0]                 bresp, rresp;
  logic [31:0]                rdata;
  logic [7:0]                 lk = 8'h00;
  logic [2:0]                 dly = 3'h0;
  link_ctrl_pkg::tag_event_t  ev = '0;
  logic [7:0]                 lk_m;
  logic [2:0]                 dly_m;
  link_ctrl_pkg::tag_event_t  ev_m;
  logic                       tmo_err, train_ok, disp_err, l1_ok, pad_on, entry_sel, hdr_alt;
  logic [2:0]                 idle_dly;
  link_ctrl_pkg::nosnoop_attr_t nosnoop;
  logic [3:0]                 qual;
  int                         num_errors = 0;
  int                         n_tests = 0;

  always #2 clk_i = ~clk_i;

  link_side_model far (.clk_i(clk_i), .rst_i(rst_i), .req_i(lk), .delay_i(dly), .ev_i(ev),
    .lvl_o(lk_m), .delay_o(dly_m), .ev_o(ev_m));

  pcie_link_control_regs dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .self_test_pass_i(lk_m[6]), .nvm_load_i(lk_m[7]), .nvm_idle_delay_i(dly_m), .cpl_timeout_hit_i(lk_m[0]),
    .cpl_timeout_err_o(tmo_err), .training_ok_i(lk_m[1]), .standby_training_ok_o(train_ok),
    .disparity_err_raw_i(lk_m[2]), .disparity_err_o(disp_err), .l1_req_i(lk_m[3]), .rx_standby_i(lk_m[4]),
    .l1_entry_allowed_o(l1_ok), .tx_standby_i(lk_m[5]), .replay_pad_active_o(pad_on),
    .deep_sleep_idle_delay_o(idle_dly), .standby_entry_delay_sel_o(entry_sel),
    .header_log_alt_order_o(hdr_alt), .nosnoop_o(nosnoop), .tag_event_i(ev_m), .qual_match_o(qual));

  task automatic close_out();
    if (num_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // address and data offered together, each released as soon as it is taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_done && w_done));
    do @(posedge clk_i); while (!bvalid);
    bready <= 1'b0;
    cmp(32'(bresp), 32'(er));
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`BIC_ADDR, d, r);
    cmp(d, `BIC_RESET);
    rd(`FTS_ADDR, d, r);
    cmp(d, `FTS_RESET);
    cmp(32'(idle_dly), 32'h7);
    cmp(32'(pad_on), 32'h1);
    cmp(32'(nosnoop), 32'h0);
  endtask

  task automatic t_set_all();
    logic [31:0] d;
    logic [1:0]  r;
    wr(`BIC_ADDR, 32'hFFFF_FFFF, `RESP_OKAY);
    rd(`BIC_ADDR, d, r);
    cmp(d, `BIC_SW_MASK | (`BIC_RESET & ~`BIC_SW_MASK));
    lk <= 8'h0D;
    settle();
    cmp(32'(tmo_err), 32'h0);
    cmp(32'(train_ok), 32'h1);
    cmp(32'(disp_err), 32'h0);
    cmp(32'(l1_ok), 32'h1);
    cmp(32'(pad_on), 32'h1);
    cmp(32'(entry_sel), 32'h1);
    cmp(32'(hdr_alt), 32'h1);
    cmp(32'(idle_dly), 32'h7);
  endtask

  task automatic t_clear_all();
    logic [31:0] d;
    logic [1:0]  r;
    wr(`BIC_ADDR, 32'h0040_0000, `RESP_OKAY);
    settle();
    cmp(32'(tmo_err), 32'h1);
    cmp(32'(train_ok), 32'h0);
    cmp(32'(disp_err), 32'h1);
    cmp(32'(l1_ok), 32'h0);
    cmp(32'(pad_on), 32'h0);
    cmp(32'(entry_sel), 32'h0);
    cmp(32'(hdr_alt), 32'h0);
    lk <= 8'h3D;
    settle();
    cmp(32'(pad_on), 32'h1);
    cmp(32'(l1_ok), 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(`BIC_ADDR, 32'h0040_0000 | (32'h1 << i), `RESP_OKAY);
      settle();
      cmp(32'(nosnoop), 32'h1 << i);
      rd(`BIC_ADDR, d, r);
      cmp(d, 32'h06C0_0000 | (32'h1 << i));
    end
  endtask

  task automatic t_selftest();
    logic [31:0] d;
    logic [1:0]  r;
    rd(`BIC_ADDR, d, r);
    cmp(32'(d[30]), 32'h0);
    @(posedge clk_i);
    lk[6] <= 1'b1;
    @(posedge clk_i);
    lk[6] <= 1'b0;
    settle();
    rd(`BIC_ADDR, d, r);
    cmp(32'(d[30]), 32'h1);
  endtask

  task automatic t_nvm();
    logic [31:0] d;
    logic [1:0]  r;
    for (int v = 7; v >= 0; v--) begin
      @(posedge clk_i);
      dly <= 3'(v);
      lk[7] <= 1'b1;
      @(posedge clk_i);
      lk[7] <= 1'b0;
      settle();
      cmp(32'(idle_dly), 32'(v));
      rd(`BIC_ADDR, d, r);
      cmp(32'({d[23], d[26:25]}), 32'(v));
    end
    // software tries to raise the read-only delay field
    wr(`BIC_ADDR, 32'h06C0_0000, `RESP_OKAY);
    rd(`BIC_ADDR, d, r);
    cmp(d, 32'h0040_0000);
  endtask

  task automatic t_tags();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 4; i++) begin
      wr(`FTS_ADDR, 32'hB3 << (8 * i), `RESP_OKAY);
      rd(`FTS_ADDR, d, r);
      cmp(d, 32'hB3 << (8 * i));
      ev <= '{1'b1, 3'h5, 5'h13};
      settle();
      cmp(32'(qual), 32'h1 << i);
      ev <= '{1'b1, 3'h5, 5'h12};
      settle();
      cmp(32'(qual), 32'h0);
      ev <= '0;
    end
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    wr(16'h5B04, 32'hFFFF_FFFF, `RESP_SLVERR);
    rd(16'h5B04, d, r);
    cmp(32'(r), 32'(`RESP_SLVERR));
    cmp(d, 32'h0);
    rd(`BIC_ADDR, d, r);
    cmp(d, 32'h0040_0000);
  endtask

  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_set_all();
    t_clear_all();
    t_selftest();
    t_nvm();
    t_tags();
    t_unmapped();
    close_out();
  end

  // roughly 40 bus cycles of a few clocks each; a generous ceiling
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
endmodule
